/* File: logic/rhp_pkg.sv */
package rhp_pkg;

  // ****************************************************************
  // command codes on the processor port (port index added to base)
  // ****************************************************************
  localparam logic [7:0] RHP_CMD_RD_BASE = 8'h15;
  localparam logic [7:0] RHP_CMD_WR_BASE = 8'h95;

  // ****************************************************************
  // bit positions of the port status register
  // ****************************************************************
  localparam int RHP_BIT_RESET_DONE_CHANGE      = 20;
  localparam int RHP_BIT_PORT_OVERCURRENT_CHANGE = 19;
  localparam int RHP_BIT_SUSPEND_CHANGE         = 18;
  localparam int RHP_BIT_ENABLE_CHANGE          = 17;
  localparam int RHP_BIT_CONNECT_CHANGE         = 16;
  localparam int RHP_BIT_SLOW_DEVICE_ATTACHED   = 9;
  localparam int RHP_BIT_PORT_POWER_ON          = 8;

  localparam logic [31:0] RHP_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] RHP_RDATA_IDLE = 32'h0000_0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int RHP_CLK_MHZ        = 250;
  localparam int RHP_US_PER_MS      = 1000;
  localparam int RHP_PORT_RESET_MS  = 10;
  localparam int RHP_PORT_RESET_CYC = RHP_PORT_RESET_MS * RHP_US_PER_MS * RHP_CLK_MHZ;
  localparam int RHP_CNT_W          = 22;

  // ****************************************************************
  // port-side signals of one downstream port
  // ****************************************************************
  typedef struct packed {
    logic reset_start;
    logic overcurrent;
    logic suspend_event;
    logic enable_event;
    logic connect_event;
    logic slow_device_attached;
    logic port_power_on;
  } rhp_port_in_t;

endpackage

/* File: logic/rhp_root_port_status.sv */
`timescale 1ns/1ns
module rhp_root_port_status
  import rhp_pkg::*;
#(
  parameter int NUM_PORTS      = 2,
  parameter int PORT_RESET_CYC = RHP_PORT_RESET_CYC
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         reg_rd,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_cmd,
  input  wire logic [31:0]  reg_wdata,
  output logic      [31:0]  reg_rdata,
  output logic              reg_rvalid,
  input  wire logic         xfer_busy,
  input  wire logic         per_port_oc_mode,
  input  wire rhp_port_in_t port_in [NUM_PORTS],
  output logic      [NUM_PORTS-1:0] port_reset_active
);

  // counter sized for the 10 ms default; a reset over 4194304 cycles needs a wider count
  localparam logic [RHP_CNT_W-1:0] RST_LAST = RHP_CNT_W'(PORT_RESET_CYC - 1);

  // change flag slice, counted from the connect change bit
  localparam int CHG_HI  = RHP_BIT_RESET_DONE_CHANGE;
  localparam int CHG_LO  = RHP_BIT_CONNECT_CHANGE;
  localparam int CHG_W   = CHG_HI - CHG_LO + 1;
  localparam int CHG_RST = RHP_BIT_RESET_DONE_CHANGE - CHG_LO;
  localparam int CHG_OC  = RHP_BIT_PORT_OVERCURRENT_CHANGE - CHG_LO;
  localparam int CHG_SUS = RHP_BIT_SUSPEND_CHANGE - CHG_LO;
  localparam int CHG_ENA = RHP_BIT_ENABLE_CHANGE - CHG_LO;
  localparam int CHG_CON = 0;

  logic [31:0] status_word [NUM_PORTS];

  // ****************************************************************
  // per-port register copies
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      logic [CHG_W-1:0]     chg;
      logic [CHG_W-1:0]     next_chg;
      logic [CHG_W-1:0]     pend_clr;
      logic [CHG_W-1:0]     next_pend_clr;
      logic [CHG_W-1:0]     clr_req;
      logic [CHG_W-1:0]     set_evt;
      logic                 oc_prev;
      logic                 next_oc_prev;
      logic                 oc_edge;
      logic                 rst_run;
      logic                 next_rst_run;
      logic [RHP_CNT_W-1:0] rst_cnt;
      logic [RHP_CNT_W-1:0] next_rst_cnt;
      logic                 rst_end;
      logic                 wr_hit;

      // each copy answers its own write code only
      assign wr_hit = reg_wr && (reg_cmd == RHP_CMD_WR_BASE + 8'(gi));

      // **************************************************************
      // port reset timer
      // **************************************************************
      always_comb begin
        next_rst_run = rst_run;
        next_rst_cnt = rst_cnt;
        rst_end      = 1'b0;
        if (rst_run) begin
          if (rst_cnt == RST_LAST) begin
            next_rst_run = 1'b0;
            next_rst_cnt = '0;
            rst_end      = 1'b1;
          end else begin
            next_rst_cnt = rst_cnt + RHP_CNT_W'(1);
          end
        end else if (port_in[gi].reset_start) begin
          // a start while running is ignored
          next_rst_run = 1'b1;
          next_rst_cnt = '0;
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          rst_run <= 1'b0;
          rst_cnt <= '0;
        end else begin
          rst_run <= next_rst_run;
          rst_cnt <= next_rst_cnt;
        end
      end

      assign port_reset_active[gi] = rst_run;

      // **************************************************************
      // overcurrent indicator tracker
      // **************************************************************
      always_comb begin
        // tracked in either mode, so a switch back finds no stale edge
        next_oc_prev = port_in[gi].overcurrent;
        // global reporting mode: indicator is not per port, flag held off
        oc_edge      = per_port_oc_mode && (port_in[gi].overcurrent != oc_prev);
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          oc_prev <= 1'b0;
        end else begin
          oc_prev <= next_oc_prev;
        end
      end

      // **************************************************************
      // clears deferred behind a running transaction
      // **************************************************************
      always_comb begin
        clr_req = pend_clr;
        // ones written collect here; zeros add nothing
        if (wr_hit) begin
          clr_req = pend_clr | reg_wdata[CHG_HI:CHG_LO];
        end
        // held while busy, spent on the first idle cycle
        next_pend_clr = xfer_busy ? clr_req : '0;
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pend_clr <= '0;
        end else begin
          pend_clr <= next_pend_clr;
        end
      end

      // **************************************************************
      // change flags
      // **************************************************************
      always_comb begin
        set_evt          = '0;
        set_evt[CHG_RST] = rst_end;
        set_evt[CHG_OC]  = oc_edge;
        set_evt[CHG_SUS] = port_in[gi].suspend_event;
        set_evt[CHG_ENA] = port_in[gi].enable_event;
        set_evt[CHG_CON] = port_in[gi].connect_event;
        next_chg         = chg;
        if (!xfer_busy) begin
          next_chg = chg & ~clr_req;
        end
        // an event in the clearing cycle survives
        next_chg = next_chg | set_evt;
        if (!per_port_oc_mode) begin
          next_chg[CHG_OC] = 1'b0;
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          chg <= '0;
        end else begin
          chg <= next_chg;
        end
      end

      // **************************************************************
      // status word of this port
      // **************************************************************
      always_comb begin
        // lower status bits and reserved bits read 0
        status_word[gi]                = RHP_REG_RESET;
        status_word[gi][CHG_HI:CHG_LO] = chg;
        // a flag caught just before the switch to global mode reads 0
        status_word[gi][RHP_BIT_PORT_OVERCURRENT_CHANGE] = chg[CHG_OC] && per_port_oc_mode;
        status_word[gi][RHP_BIT_SLOW_DEVICE_ATTACHED] = port_in[gi].slow_device_attached;
        status_word[gi][RHP_BIT_PORT_POWER_ON]        = port_in[gi].port_power_on;
      end
    end
  endgenerate

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] next_rdata;
  logic        next_rvalid;

  always_comb begin
    next_rdata  = reg_rdata;
    next_rvalid = reg_rd;
    if (reg_rd) begin
      next_rdata = RHP_RDATA_IDLE;
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (reg_cmd == RHP_CMD_RD_BASE + 8'(i)) begin
          next_rdata = status_word[i];
        end
      end
    end
  end

  // ****************************************************************
  // read data register
  // ****************************************************************
  // data holds between reads, so a slow poller still sees the last word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= RHP_RDATA_IDLE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

endmodule // rhp_root_port_status

/* File: tb/rhp_props.sv */
`timescale 1ns/1ns
module rhp_props
  import rhp_pkg::*;
#(parameter int NUM_PORTS = 2, parameter int PORT_RESET_CYC = 8) (
  input logic                 clk,
  input logic                 rstn,
  input logic                 reg_rd,
  input logic                 reg_wr,
  input logic [7:0]           reg_cmd,
  input logic [31:0]          reg_wdata,
  input logic [31:0]          reg_rdata,
  input logic                 reg_rvalid,
  input logic                 xfer_busy,
  input logic                 per_port_oc_mode,
  input logic [NUM_PORTS-1:0] port_reset_active
);
  localparam int FALL_D = PORT_RESET_CYC - 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd0; reg_rd && reg_cmd == RHP_CMD_RD_BASE; endsequence
  sequence wr0; reg_wr && reg_cmd == RHP_CMD_WR_BASE; endsequence
  sequence run_end; ##FALL_D $fell(port_reset_active[0]); endsequence
  read_answer_a: assert property (reg_rvalid == $past(reg_rd)) else $error("rvalid");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("hold");
  reserved_zero_a: assert property (reg_rvalid |-> !(reg_rdata & 32'hFFE0_FCFF))
    else $error("reserved bits");
  oc_global_a: assert property (reg_rd && !per_port_oc_mode |=> !reg_rdata[19])
    else $error("oc flag in global mode");
  reset_len_a: assert property ($rose(port_reset_active[0]) |=> run_end)
    else $error("reset length");
  done_set_a: assert property ($fell(port_reset_active[0]) ##0 rd0 |=> reg_rdata[20])
    else $error("reset done flag");
  clear_now_a: assert property (wr0 ##0 (reg_wdata[20] && !xfer_busy
    && !port_reset_active[0]) ##1 rd0 |=> !reg_rdata[20]) else $error("no clear");
  clear_defer_a: assert property (rd0 ##0 xfer_busy ##1 xfer_busy[*2] ##1 rd0 ##0 xfer_busy
    |=> reg_rdata[20] || !$past(reg_rdata[20], 3)) else $error("clear not deferred");
endmodule // rhp_props
bind rhp_root_port_status rhp_props #(.NUM_PORTS(NUM_PORTS), .PORT_RESET_CYC(PORT_RESET_CYC))
  props_u (.clk, .rstn, .reg_rd, .reg_wr, .reg_cmd, .reg_wdata, .reg_rdata, .reg_rvalid,
  .xfer_busy, .per_port_oc_mode, .port_reset_active);

/* File: tb/rhp_dev_model.sv */
`timescale 1ns/1ns
module rhp_dev_model
  import rhp_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic oc,
  input wire logic att,
  input wire logic pwr,
  output rhp_port_in_t p
);
  logic att_q = 1'b0;
  // launched after the edge so the device never races its sampling edge
  always @(posedge clk) begin
    p <= #1 '{go, oc, 1'b0, 1'b0, att != att_q, att, pwr};
    att_q <= att;
  end
endmodule // rhp_dev_model

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %0t got %h want %h", $time, a, e); end end
module testbench;
  import rhp_pkg::*;
  localparam logic [7:0] R0 = RHP_CMD_RD_BASE, R1 = R0 + 8'h01;
  localparam logic [7:0] W0 = RHP_CMD_WR_BASE, W1 = W0 + 8'h01;
  localparam logic [31:0] P = 32'h0000_0100, RD = 32'h0010_0000, OC = 32'h0008_0000;
  logic clk = 1'b0, rstn = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, busy = 1'b0, mode = 1'b1;
  logic [7:0] reg_cmd = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_rvalid;
  logic [1:0] go = 2'h0, oc = 2'h0, att = 2'h0, pwr = 2'h1, act;
  wire rhp_port_in_t port_in [2];
  int mismatches = 0, total_checks = 0, i, n;
  always #2 clk = ~clk;
  rhp_dev_model d0_u (.clk, .go(go[0]), .oc(oc[0]), .att(att[0]), .pwr(pwr[0]), .p(port_in[0]));
  rhp_dev_model d1_u (.clk, .go(go[1]), .oc(oc[1]), .att(att[1]), .pwr(pwr[1]), .p(port_in[1]));
  rhp_root_port_status #(.NUM_PORTS(2), .PORT_RESET_CYC(8)) dut_u (.clk, .rstn, .reg_rd,
    .reg_wr, .reg_cmd, .reg_wdata, .reg_rdata, .reg_rvalid, .xfer_busy(busy),
    .per_port_oc_mode(mode), .port_in, .port_reset_active(act));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    {reg_wr, reg_cmd, reg_wdata} = {1'b1, c, d};
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] e);
    {reg_rd, reg_cmd} = {1'b1, c};
    tick(1);
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
    reg_rd = 1'b0;
    tick(1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(12);
    rstn = 1'b1;
    begin : run_tests
      rd(R0, P);
      rd(8'h17, 32'h0);
      $display("test reset done");
      go[0] = 1'b1;
      tick(1);
      go[0] = 1'b0;
      for (i = 0; i < 50 && !act[0]; i++) tick(1);
      for (n = 0; n < 50 && act[0]; n++) tick(1);
      `CHK(n, 8)
      // a stuck timer ends the run at the report
      if (i == 50 || n == 50) begin
        mismatches++;
        disable run_tests;
      end
      rd(R0, RD | P);
      rd(R1, 32'h0);
      wr(W0, ~RD);
      rd(R0, RD | P);
      busy = 1'b1;
      rd(R0, RD | P);
      wr(W0, RD);
      rd(R0, RD | P);
      busy = 1'b0;
      tick(1);
      rd(R0, P);
      $display("test port reset done");
      oc[0] = 1'b1;
      tick(3);
      rd(R0, OC | P);
      wr(W0, 32'h0);
      rd(R0, OC | P);
      wr(W0, OC | RD);
      rd(R0, P);
      oc[0] = 1'b0;
      mode = 1'b0;
      tick(3);
      rd(R0, P);
      mode = 1'b1;
      rd(R0, P);
      oc[0] = 1'b1;
      tick(3);
      rd(R0, OC | P);
      $display("test overcurrent done");
      att[1] = 1'b1;
      tick(3);
      rd(R1, 32'h0001_0200);
      wr(W1, 32'h0001_0000);
      rd(R1, 32'h0000_0200);
      rd(R0, OC | P);
      $display("test connect done");
    end
    summarize();
  end
endmodule // testbench
